// [rtl/cicr_top.sv]
/*
  Core interrupt control block: control register with gates, enables and
  flags, priority control, event status and mask, and the CPU requests.
  Assumes a register port master that never issues read and write at
  once, synchronous source inputs and a one-cycle timer overflow pulse.
*/
// The register addresses and the strobed register port were decided locally.
`include "cicr_map.svh"

module cicr_top (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // register port
  input wire cicr_pkg::cicr_addr_t addr_in,
  input wire cicr_pkg::cicr_byte_t wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output cicr_pkg::cicr_byte_t rdata_out,
  // interrupt sources
  input wire logic timer_zero_overflow_in,
  input wire logic ext_pin_in,
  input wire cicr_pkg::cicr_nib_t port_upper_nibble_pins_in,
  input wire logic periph_high_req_in,
  input wire logic periph_low_req_in,
  // requests to the CPU and event interrupt
  output logic irq_high_out,
  output logic irq_low_out,
  output logic irq_out
);
  import cicr_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // address decode, shared by writes and reads
  function automatic logic addr_hit(input cicr_addr_t a,
                                    input cicr_addr_t off);
    return a == off;
  endfunction : addr_hit

  logic [7:3] ctrl_en_reg;
  cicr_src_t flag_reg;
  cicr_nib_t prio_reg;
  cicr_src_t status_reg;
  cicr_src_t mask_reg;
  logic ext_prev_reg;
  logic mismatch;
  cicr_src_t flag_set;
  cicr_src_t core_pend;
  cicr_byte_t ctrl_q;
  logic wr_ctrl;
  logic rd_stat;
  logic port_read;
  logic global_irq_gate;
  logic periph_irq_gate;
  logic priority_scheme_en;
  logic req_high;
  logic req_low;

  assign wr_ctrl = wr_in && addr_hit(addr_in, `CICR_OFF_CTRL);
  assign rd_stat = rd_in && addr_hit(addr_in, `CICR_OFF_STAT);
  assign port_read = rd_in && addr_hit(addr_in, `CICR_OFF_PORT);
  assign ctrl_q = {ctrl_en_reg, flag_reg};
  assign global_irq_gate = ctrl_en_reg[`CICR_BIT_GLOBAL];
  assign periph_irq_gate = ctrl_en_reg[`CICR_BIT_PERIPH];
  assign priority_scheme_en = prio_reg[`CICR_BIT_PRIO_EN];

  ////////////////////////////////////////////////////////////////////////
  // port-change detector; the read of the port register re-arms it
  cicr_port_change u_port_change (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .pins_in(port_upper_nibble_pins_in),
    .port_read_in(port_read),
    .mismatch_out(mismatch)
  );

  // external pin edge detect, rising edge only
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ext_prev_reg <= 1'b0;
    end else begin
      ext_prev_reg <= ext_pin_in;
    end
  end

  // hardware set terms, bit order timer, external pin, port change
  assign flag_set[`CICR_BIT_TMR_FLAG] = timer_zero_overflow_in;
  assign flag_set[`CICR_BIT_EXT_FLAG] = ext_pin_in && !ext_prev_reg;
  assign flag_set[`CICR_BIT_PORT_FLAG] = mismatch;

  ////////////////////////////////////////////////////////////////////////
  // gate and enable bits of the control register
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      ctrl_en_reg <= 5'(`CICR_RST_CTRL >> 3);
    end else if (wr_ctrl) begin
      ctrl_en_reg <= wdata_in[7:3];
    end
  end

  // flags and event status: the hardware set wins over any clear, so an
  // event landing on the clearing write is never lost
  for (genvar i = 0; i < 3; i++) begin : g_flag
    always_ff @(posedge clk_in) begin
      if (reset_in) begin
        flag_reg[i] <= 1'b0;
      end else if (flag_set[i]) begin
        flag_reg[i] <= 1'b1;
      end else if (wr_ctrl) begin
        flag_reg[i] <= wdata_in[i];
      end
    end

    always_ff @(posedge clk_in) begin
      if (reset_in) begin
        status_reg[i] <= 1'b0;
      end else if (flag_set[i]) begin
        status_reg[i] <= 1'b1;
      end else if (rd_stat) begin
        status_reg[i] <= 1'b0;
      end
    end
  end

  // priority control and event mask
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      prio_reg <= `CICR_RST_PRIO;
      mask_reg <= `CICR_RST_MASK;
    end else if (wr_in) begin
      if (addr_hit(addr_in, `CICR_OFF_PRIO)) begin
        prio_reg <= wdata_in[3:0];
      end
      if (addr_hit(addr_in, `CICR_OFF_MASK)) begin
        mask_reg <= wdata_in[2:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data stand only in the cycle after the strobe; unmapped reads 0
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      case (addr_in)
        `CICR_OFF_CTRL: rdata_out <= ctrl_q;
        `CICR_OFF_PRIO: rdata_out <= {4'h0, prio_reg};
        `CICR_OFF_STAT: rdata_out <= {5'h00, status_reg};
        `CICR_OFF_MASK: rdata_out <= {5'h00, mask_reg};
        `CICR_OFF_PORT: rdata_out <= {4'h0, port_upper_nibble_pins_in};
        default: rdata_out <= 8'h00;
      endcase
    end else begin
      rdata_out <= 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pending core sources: flag and its enable, bits 5:3 pair with 2:0
  assign core_pend = flag_reg & ctrl_en_reg[5:3];

  // gating by scheme; in priority mode the global gate also blocks low
  always_comb begin
    if (priority_scheme_en) begin
      req_high = global_irq_gate &&
                 ((|(core_pend & prio_reg[3:1])) ||
                  periph_high_req_in);
      req_low = global_irq_gate && periph_irq_gate &&
                ((|(core_pend & ~prio_reg[3:1])) ||
                 periph_low_req_in);
    end else begin
      req_high = global_irq_gate &&
                 ((|core_pend) ||
                  (periph_irq_gate &&
                   (periph_high_req_in || periph_low_req_in)));
      req_low = 1'b0;
    end
  end

  // registered requests; one cycle behind the register state
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      irq_high_out <= 1'b0;
      irq_low_out <= 1'b0;
    end else begin
      irq_high_out <= req_high;
      irq_low_out <= req_low;
    end
  end

  // event interrupt level from status under mask
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      irq_out <= 1'b0;
    end else begin
      irq_out <= |(status_reg & mask_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  property p_tmr_flag;
    @(posedge clk_in) disable iff (reset_in)
    timer_zero_overflow_in |=> flag_reg[`CICR_BIT_TMR_FLAG];
  endproperty
  a_tmr_flag: assert property (p_tmr_flag)
    else $error("timer overflow did not set its flag");

  property p_ext_flag;
    @(posedge clk_in) disable iff (reset_in)
    (ext_pin_in && !ext_prev_reg) |=> flag_reg[`CICR_BIT_EXT_FLAG];
  endproperty
  a_ext_flag: assert property (p_ext_flag)
    else $error("external pin edge did not set its flag");

  property p_port_flag;
    @(posedge clk_in) disable iff (reset_in)
    mismatch |=> flag_reg[`CICR_BIT_PORT_FLAG];
  endproperty
  a_port_flag: assert property (p_port_flag)
    else $error("port mismatch did not hold its flag set");

  property p_flag_hold;
    @(posedge clk_in) disable iff (reset_in)
    (flag_reg[`CICR_BIT_EXT_FLAG] && !wr_ctrl) |=>
      flag_reg[`CICR_BIT_EXT_FLAG];
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("flag cleared without a software write");

  property p_global_off;
    @(posedge clk_in) disable iff (reset_in)
    !global_irq_gate |=> (!irq_high_out && !irq_low_out);
  endproperty
  a_global_off: assert property (p_global_off)
    else $error("request raised with the global gate closed");

  property p_periph_off;
    @(posedge clk_in) disable iff (reset_in)
    (!priority_scheme_en && !periph_irq_gate && core_pend == 3'h0) |=>
      !irq_high_out;
  endproperty
  a_periph_off: assert property (p_periph_off)
    else $error("peripheral request passed a closed peripheral gate");

  property p_low_off;
    @(posedge clk_in) disable iff (reset_in)
    (!priority_scheme_en || !periph_irq_gate) |=> !irq_low_out;
  endproperty
  a_low_off: assert property (p_low_off)
    else $error("low request raised with low gate closed");

  property p_core_req;
    @(posedge clk_in) disable iff (reset_in)
    (global_irq_gate && !priority_scheme_en && core_pend != 3'h0) |=>
      irq_high_out;
  endproperty
  a_core_req: assert property (p_core_req)
    else $error("enabled flag did not raise the request");

  // write, one quiet cycle, then the read back of the same byte
  property p_ctrl_rw;
    @(posedge clk_in) disable iff (reset_in)
    (wr_ctrl && flag_set == 3'h0) ##1 (!wr_ctrl && flag_set == 3'h0) ##1
      (rd_in && addr_in == `CICR_OFF_CTRL) |=>
      rdata_out == $past(wdata_in, 3);
  endproperty
  a_ctrl_rw: assert property (p_ctrl_rw)
    else $error("control read back differs from written byte");

  property p_tmr_hold;
    @(posedge clk_in) disable iff (reset_in)
    (flag_reg[`CICR_BIT_TMR_FLAG] && !wr_ctrl) |=>
      flag_reg[`CICR_BIT_TMR_FLAG];
  endproperty
  a_tmr_hold: assert property (p_tmr_hold)
    else $error("timer flag cleared without a software write");

  property p_port_hold;
    @(posedge clk_in) disable iff (reset_in)
    (flag_reg[`CICR_BIT_PORT_FLAG] && !wr_ctrl) |=>
      flag_reg[`CICR_BIT_PORT_FLAG];
  endproperty
  a_port_hold: assert property (p_port_hold)
    else $error("port flag cleared without a software write");

  // a control write lands whole unless a hardware set meets it
  property p_ctrl_write;
    @(posedge clk_in) disable iff (reset_in)
    (wr_ctrl && flag_set == 3'h0) |=> ctrl_q == $past(wdata_in);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write)
    else $error("control write did not land");

  property p_en_hold;
    @(posedge clk_in) disable iff (reset_in)
    !wr_ctrl |=> $stable(ctrl_en_reg);
  endproperty
  a_en_hold: assert property (p_en_hold)
    else $error("gate or enable bit moved without a write");

  property p_port_clear;
    @(posedge clk_in) disable iff (reset_in)
    (wr_ctrl && !mismatch && !wdata_in[`CICR_BIT_PORT_FLAG]) |=>
      !flag_reg[`CICR_BIT_PORT_FLAG];
  endproperty
  a_port_clear: assert property (p_port_clear)
    else $error("port flag not cleared after the mismatch ended");

  property p_periph_on;
    @(posedge clk_in) disable iff (reset_in)
    (!priority_scheme_en && global_irq_gate && periph_irq_gate &&
     (periph_high_req_in || periph_low_req_in)) |=> irq_high_out;
  endproperty
  a_periph_on: assert property (p_periph_on)
    else $error("peripheral request blocked by open gates");

  property p_en_off;
    @(posedge clk_in) disable iff (reset_in)
    (!priority_scheme_en && core_pend == 3'h0 &&
     !(periph_irq_gate && (periph_high_req_in || periph_low_req_in))) |=>
      !irq_high_out;
  endproperty
  a_en_off: assert property (p_en_off)
    else $error("request raised with no enabled flag pending");

  property p_high_core;
    @(posedge clk_in) disable iff (reset_in)
    (priority_scheme_en && global_irq_gate &&
     (core_pend & prio_reg[3:1]) != 3'h0) |=> irq_high_out;
  endproperty
  a_high_core: assert property (p_high_core)
    else $error("high-priority source did not raise the request");

  property p_high_periph;
    @(posedge clk_in) disable iff (reset_in)
    (priority_scheme_en && global_irq_gate && periph_high_req_in) |=>
      irq_high_out;
  endproperty
  a_high_periph: assert property (p_high_periph)
    else $error("high peripheral request did not pass the open gate");

  property p_low_req;
    @(posedge clk_in) disable iff (reset_in)
    (priority_scheme_en && global_irq_gate && periph_irq_gate &&
     periph_low_req_in) |=> irq_low_out;
  endproperty
  a_low_req: assert property (p_low_req)
    else $error("low peripheral request did not pass the open gates");

  // read data must not linger, the master takes them blindly
  property p_rdata_idle;
    @(posedge clk_in) disable iff (reset_in)
    !rd_in |=> rdata_out == 8'h00;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data stood without a read strobe");

endmodule : cicr_top

// [rtl/cicr_map.svh]
/*
  Constants of the core interrupt control block: register offsets, bit
  positions, reset values and the instruction-cycle count.
  Assumes a 100 MHz clk_in and an instruction cycle of four clocks.
*/
// Operation
// - flags set on condition, ignoring all enables
// - no priority: bit 7 gates every interrupt; irq_out is not gated by it
// - priority: bit 7 gates high, blocks all; irq_out is not blocked by it
// - no priority: bit 6 gates peripheral interrupts
// - priority: bit 6 gates low-priority interrupts
// - bit 5 enables timer-zero overflow interrupt
// - bit 4 enables external pin interrupt
// - bit 3 enables port-change interrupt
// - bit 2 timer overflow flag, sticky
// - bit 1 external pin flag, sticky
// - bit 0 upper-nibble port change flag, sticky
// - mismatch re-sets flag until port read; the code ends the mismatch one instruction cycle after the read
// - control register readable and writable, one byte
`ifndef CICR_MAP_SVH
`define CICR_MAP_SVH

// register offsets on the register port
`define CICR_OFF_CTRL 4'h0
`define CICR_OFF_PRIO 4'h1
`define CICR_OFF_STAT 4'h2
`define CICR_OFF_MASK 4'h3
`define CICR_OFF_PORT 4'h4

// control register bit positions
`define CICR_BIT_GLOBAL 7
`define CICR_BIT_PERIPH 6
`define CICR_BIT_TMR_EN 5
`define CICR_BIT_EXT_EN 4
`define CICR_BIT_PORT_EN 3
`define CICR_BIT_TMR_FLAG 2
`define CICR_BIT_EXT_FLAG 1
`define CICR_BIT_PORT_FLAG 0

// priority register: bit 0 scheme enable, bits 3:1 source priorities
`define CICR_BIT_PRIO_EN 0

// reset values
`define CICR_RST_CTRL 8'h00
`define CICR_RST_PRIO 4'h0
`define CICR_RST_MASK 3'h0

// clocks in one instruction cycle (Fosc/4)
`define CICR_INSTR_CLKS 3'h4

`endif

// [rtl/cicr_pkg.sv]
/*
  Types shared by the core interrupt control block.
  Assumes cicr_map.svh supplies the numeric constants.
*/
package cicr_pkg;
  typedef logic [7:0] cicr_byte_t;
  typedef logic [3:0] cicr_addr_t;
  typedef logic [3:0] cicr_nib_t;
  typedef logic [2:0] cicr_src_t;
  // port-change latch sequencer
  typedef enum logic [0:0] {
    CICR_PC_IDLE = 1'b0,
    CICR_PC_WAIT = 1'b1
  } cicr_pc_state_e;
endpackage : cicr_pkg

// [rtl/cicr_port_change.sv]
/*
  Upper-nibble port-change detector: keeps the last value read from the
  port and reports a mismatch against the live pins.
  Assumes pins are synchronous to clk_in and port_read_in is one cycle.
*/
`include "cicr_map.svh"

module cicr_port_change (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // pins and port read strobe
  input wire cicr_pkg::cicr_nib_t pins_in,
  input wire logic port_read_in,
  // mismatch level
  output logic mismatch_out
);
  import cicr_pkg::*;

  cicr_pc_state_e state_reg;
  cicr_nib_t snap_reg;
  cicr_nib_t latch_reg;
  logic [2:0] wait_reg;

  ////////////////////////////////////////////////////////////////////////
  // a read only ends the mismatch one instruction cycle later
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      state_reg <= CICR_PC_IDLE;
      wait_reg <= 3'h0;
      snap_reg <= 4'h0;
      latch_reg <= 4'h0;
    end else begin
      case (state_reg)
        CICR_PC_IDLE: begin
          if (port_read_in) begin
            snap_reg <= pins_in;
            wait_reg <= `CICR_INSTR_CLKS - 3'h1;
            state_reg <= CICR_PC_WAIT;
          end
        end
        CICR_PC_WAIT: begin
          if (wait_reg == 3'h1) begin
            latch_reg <= snap_reg;
            state_reg <= CICR_PC_IDLE;
          end
          wait_reg <= wait_reg - 3'h1;
        end
        default: begin
          state_reg <= CICR_PC_IDLE;
        end
      endcase
    end
  end

  // mismatch level, registered
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      mismatch_out <= 1'b0;
    end else begin
      mismatch_out <= (pins_in != latch_reg);
    end
  end

  property p_read_ends;
    @(posedge clk_in) disable iff (reset_in)
    (port_read_in && state_reg == CICR_PC_IDLE) |->
      ##4 (latch_reg == $past(pins_in, 4));
  endproperty
  a_read_ends: assert property (p_read_ends)
    else $error("port read did not update latch after four clocks");

endmodule : cicr_port_change

// [rtl/_unused_guard.sv]
/*
  Intentionally empty compilation unit kept out of the build.
  Assumes nothing.
*/

// [tb/cicr_cpu_model.sv]
/*
  Behavioural CPU core that takes the block's interrupt requests.
  Assumes level requests that are registered on clk_in.
*/
module cicr_cpu_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // requests from the block
  input wire logic irq_high_in,
  input wire logic irq_low_in,
  // vector in service: 2'h2 high, 2'h1 low
  output logic [1:0] vec_out
);
  //////////////////////////////////////////////////////////////////////////
  // high preempts low; one cycle late, as a core branching to a vector is
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      vec_out <= 2'h0;
    end else begin
      vec_out <= irq_high_in ? 2'h2 : {1'b0, irq_low_in};
    end
  end
endmodule : cicr_cpu_model

// [tb/tb.sv]
/*
  Self-checking bench of the core interrupt control block.
  Assumes cicr_top and the cpu model; reads are checked by a monitor.
*/
`include "cicr_map.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import cicr_pkg::*;
  logic clk_in = 1'b0;
  logic reset_in = 1'b1;
  cicr_addr_t addr_in = 4'h0;
  cicr_byte_t wdata_in = 8'h00;
  logic wr_in = 1'b0;
  logic rd_in = 1'b0;
  logic tmr_in = 1'b0;
  logic ext_in = 1'b0;
  logic ph_in = 1'b0;
  logic pl_in = 1'b0;
  cicr_nib_t pins_in = 4'h0;
  cicr_byte_t rdata_out;
  logic irq_high_out;
  logic irq_low_out;
  logic irq_out;
  logic [1:0] vec;
  logic rd_q = 1'b0;
  cicr_byte_t exp_q[$];
  cicr_byte_t st = 8'h00;
  cicr_byte_t d;
  int mismatches = 0;
  int n_tests = 0;
  int cyc = 0;
  int seed = 49449;

  cicr_top dut (.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in),
    .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .timer_zero_overflow_in(tmr_in),
    .ext_pin_in(ext_in), .port_upper_nibble_pins_in(pins_in),
    .periph_high_req_in(ph_in), .periph_low_req_in(pl_in),
    .irq_high_out(irq_high_out), .irq_low_out(irq_low_out),
    .irq_out(irq_out));
  cicr_cpu_model cpu (.clk_in(clk_in), .reset_in(reset_in),
    .irq_high_in(irq_high_out), .irq_low_in(irq_low_out), .vec_out(vec));

  //////////////////////////////////////////////////////////////////////////
  // clock
  always #5 clk_in = ~clk_in;

  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict

  task automatic check_rd(input cicr_byte_t e);
    n_tests++;
    if (rdata_out !== e) begin
      mismatches++;
      $display("[FAIL] rdata expected %h seen %h", e, rdata_out);
    end
  endtask : check_rd

  // requests settle one edge after a register change, the core one more;
  // sampled at the fourth edge, before that edge's updates land
  task automatic chk_irq(input logic [2:0] e);
    logic [4:0] x;
    x = {e, e[2] ? 2'h2 : {1'b0, e[1]}};
    repeat (4) @(posedge clk_in);
    n_tests++;
    if ({irq_high_out, irq_low_out, irq_out, vec} !== x) begin
      mismatches++;
      $display("[FAIL] irq expected %h seen %h", x,
        {irq_high_out, irq_low_out, irq_out, vec});
    end
  endtask : chk_irq

  //////////////////////////////////////////////////////////////////////////
  // read monitor: data stand only in the cycle after the strobe
  always @(posedge clk_in) begin
    cyc++;
    if (rd_q) check_rd(exp_q.pop_front());
    rd_q <= rd_in;
    if (cyc == 5000) begin
      mismatches++;
      print_verdict();
    end
  end

  task automatic wr(input cicr_addr_t a, input cicr_byte_t v);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask : wr

  task automatic rd(input cicr_addr_t a, input cicr_byte_t e);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_in);
    rd_in <= 1'b0;
  endtask : rd

  // source s: 2 timer pulse, 1 ext rising edge, 0 random pin change
  task automatic ev(input int s);
    @(posedge clk_in);
    if (s == 2) tmr_in <= 1'b1;
    else if (s == 1) ext_in <= 1'b1;
    else pins_in <= pins_in ^ (4'($random(seed)) | 4'h1);
    st = st | (8'h01 << s);
    @(posedge clk_in);
    tmr_in <= 1'b0;
    ext_in <= 1'b0;
  endtask : ev

  // port read, then a full instruction cycle, before flags are cleared
  task automatic clr;
    rd(`CICR_OFF_PORT, {4'h0, pins_in});
    repeat (5) @(posedge clk_in);
    wr(`CICR_OFF_CTRL, 8'h00);
    rd(`CICR_OFF_CTRL, 8'h00);
    rd(`CICR_OFF_STAT, st);
    st = 8'h00;
  endtask : clr

  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    repeat (6) @(posedge clk_in);
    reset_in <= 1'b0;
    rd(`CICR_OFF_CTRL, 8'h00);
    rd(`CICR_OFF_PRIO, 8'h00);
    rd(`CICR_OFF_MASK, 8'h00);
    rd(4'h9, 8'h00);
    for (int i = 0; i < 4; i++) begin
      d = 8'($random(seed)) & 8'hF8;
      wr(`CICR_OFF_CTRL, d);
      wr(4'h9, 8'hFF);
      rd(`CICR_OFF_CTRL, d);
    end
    wr(`CICR_OFF_CTRL, 8'h00);
    $display("test register access done");
    for (int s = 2; s >= 0; s--) ev(s);
    rd(`CICR_OFF_CTRL, 8'h07);
    chk_irq(3'h0);
    wr(`CICR_OFF_CTRL, 8'h00);
    rd(`CICR_OFF_CTRL, 8'h01);
    clr();
    $display("test flags done");
    // flags are clear here, so each enable goes on before its event
    for (int s = 0; s < 3; s++) begin
      wr(`CICR_OFF_CTRL, 8'h80 | (8'h08 << s));
      chk_irq(3'h0);
      ev(s);
      chk_irq(3'h4);
      wr(`CICR_OFF_CTRL, 8'h09 << s);
      chk_irq(3'h0);
      wr(`CICR_OFF_CTRL, 8'h80 | (8'h01 << s));
      chk_irq(3'h0);
      clr();
    end
    ph_in <= 1'b1;
    wr(`CICR_OFF_CTRL, 8'h80);
    chk_irq(3'h0);
    wr(`CICR_OFF_CTRL, 8'hC0);
    chk_irq(3'h4);
    wr(`CICR_OFF_CTRL, 8'h40);
    chk_irq(3'h0);
    ph_in <= 1'b0;
    $display("test gates done");
    wr(`CICR_OFF_PRIO, 8'h01);
    ev(2);
    wr(`CICR_OFF_CTRL, 8'hA4);
    chk_irq(3'h0);
    wr(`CICR_OFF_CTRL, 8'hE4);
    chk_irq(3'h2);
    wr(`CICR_OFF_PRIO, 8'h09);
    chk_irq(3'h4);
    wr(`CICR_OFF_CTRL, 8'h64);
    chk_irq(3'h0);
    pl_in <= 1'b1;
    wr(`CICR_OFF_CTRL, 8'h80);
    chk_irq(3'h0);
    wr(`CICR_OFF_CTRL, 8'hC0);
    chk_irq(3'h2);
    pl_in <= 1'b0;
    ph_in <= 1'b1;
    chk_irq(3'h4);
    ph_in <= 1'b0;
    wr(`CICR_OFF_PRIO, 8'h00);
    clr();
    $display("test priority done");
    wr(`CICR_OFF_MASK, 8'h02);
    ev(1);
    chk_irq(3'h1);
    ev(2);
    rd(`CICR_OFF_STAT, 8'h06);
    st = 8'h00;
    chk_irq(3'h0);
    ev(2);
    chk_irq(3'h0);
    wr(`CICR_OFF_MASK, 8'h00);
    clr();
    $display("test event status done");
    print_verdict();
  end
endmodule : tb
